// *** gpi_pkg.sv ***
// shared constants and types of the gpio input, pull and change-flag block
package gpi_pkg;
  localparam int GPI_PINS = 8;
  // -------------------------------------------------------------------------
  // register pointers
  // -------------------------------------------------------------------------
  localparam logic [7:0] GPI_OFF_DIR = 8'h03;
  localparam logic [7:0] GPI_OFF_EXPECT = 8'h09;
  localparam logic [7:0] GPI_OFF_PULL_EN = 8'h0b;
  localparam logic [7:0] GPI_OFF_PULL_DIR = 8'h0d;
  localparam logic [7:0] GPI_OFF_LEVEL = 8'h0f;
  localparam logic [7:0] GPI_OFF_MASK = 8'h11;
  localparam logic [7:0] GPI_OFF_FLAGS = 8'h13;
  // -------------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------------
  localparam logic [7:0] GPI_RST_DIR = 8'h00;
  localparam logic [7:0] GPI_RST_EXPECT = 8'h00;
  localparam logic [7:0] GPI_RST_PULL_EN = 8'hff;
  localparam logic [7:0] GPI_RST_PULL_DIR = 8'h00;
  localparam logic [7:0] GPI_RST_MASK = 8'h00;
  localparam logic [7:0] GPI_RST_FLAGS = 8'h00;
  localparam logic [7:0] GPI_RST_ARMED = 8'hff;
  localparam logic [7:0] GPI_RD_UNMAPPED = 8'h00;
  // arbitrary slave address, not tied to any real part
  localparam logic [6:0] GPI_DEV_ADDR_DFLT = 7'h2a;
  localparam logic [2:0] GPI_LAST_BIT = 3'h7;
  // -------------------------------------------------------------------------
  // serial engine states
  // -------------------------------------------------------------------------
  typedef enum logic [8:0] {
    GPI_IDLE  = 9'h001,
    GPI_ADDR  = 9'h002,
    GPI_AACK  = 9'h004,
    GPI_PTR   = 9'h008,
    GPI_PACK  = 9'h010,
    GPI_WDATA = 9'h020,
    GPI_WACK  = 9'h040,
    GPI_RDATA = 9'h080,
    GPI_MACK  = 9'h100
  } gpi_state_e;
endpackage

// *** gpi_link.sv ***
// serial-clock side bit capture: samples the data line on each clock rise
`timescale 1ns/1ps
`default_nettype none
module gpi_link (
  input wire logic scl,
  input wire logic rst,
  input wire logic sda_i,
  output logic bit_q,
  output logic bit_tog
);
  // -------------------------------------------------------------------------
  // capture
  // -------------------------------------------------------------------------
  // the bit is held until the next rise, long enough for the toggle to cross
  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      bit_q <= 1'b0;
      bit_tog <= 1'b0;
    end else begin
      bit_q <= sda_i;
      bit_tog <= ~bit_tog;
    end
  end
endmodule
`default_nettype wire

// *** gpi_top.sv ***
// gpio input side: expected level, pulls, level status, change flags, serial registers
`timescale 1ns/1ps
`default_nettype none
module gpi_top
  import gpi_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = GPI_DEV_ADDR_DFLT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [GPI_PINS-1:0] pin_in,
  output logic [GPI_PINS-1:0] pull_up_en,
  output logic [GPI_PINS-1:0] pull_dn_en,
  output logic int_n_o,
  output logic int_oe
);
  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  typedef struct packed {
    gpi_state_e st;
    logic [7:0] sh;
    logic [2:0] cnt;
    logic ph;
    logic rnw;
    logic wr_done;
    logic [7:0] ptr;
    logic [7:0] dir;
    logic [7:0] expect_lvl;
    logic [7:0] pull_en;
    logic [7:0] pull_dir;
    logic [7:0] mask;
    logic [7:0] flags;
    logic [7:0] armed;
    logic [7:0] pin_s1;
    logic [7:0] level;
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic tog_s1;
    logic tog_s2;
    logic tog_d;
    logic sda_oe;
    logic int_oe;
    logic [7:0] pull_up;
    logic [7:0] pull_dn;
  } gpi_s;

  gpi_s s_reg;
  gpi_s s_next;
  logic bit_q;
  logic bit_tog;
  logic [7:0] set_vec;
  logic [7:0] rearm_vec;
  logic [7:0] clr_vec;
  logic [7:0] rd_data;
  logic rd_load;
  logic bit_ev;
  logic fall;
  logic start_c;
  logic stop_c;

  gpi_link u_link (
    .scl(scl),
    .rst(rst),
    .sda_i(sda_i),
    .bit_q(bit_q),
    .bit_tog(bit_tog)
  );

  // -------------------------------------------------------------------------
  // per-pin change detection
  // -------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < GPI_PINS; gi++) begin : g_pin
      // differs from default on an input that has been back at default since
      assign set_vec[gi] = (s_reg.level[gi] ^ s_reg.expect_lvl[gi]) & ~s_reg.dir[gi] & s_reg.armed[gi];
      assign rearm_vec[gi] = ~(s_reg.level[gi] ^ s_reg.expect_lvl[gi]);
    end
  endgenerate

  always_comb begin
    unique case (s_reg.ptr)
      GPI_OFF_DIR: rd_data = s_reg.dir;
      GPI_OFF_EXPECT: rd_data = s_reg.expect_lvl;
      GPI_OFF_PULL_EN: rd_data = s_reg.pull_en;
      GPI_OFF_PULL_DIR: rd_data = s_reg.pull_dir;
      GPI_OFF_LEVEL: rd_data = s_reg.level;
      GPI_OFF_MASK: rd_data = s_reg.mask;
      GPI_OFF_FLAGS: rd_data = s_reg.flags;
      default: rd_data = GPI_RD_UNMAPPED;
    endcase
  end

  assign bit_ev = s_reg.tog_s2 ^ s_reg.tog_d;
  assign fall = s_reg.scl_d & ~s_reg.scl_s2;
  assign start_c = s_reg.scl_s2 & s_reg.scl_d & s_reg.sda_d & ~s_reg.sda_s2;
  assign stop_c = s_reg.scl_s2 & s_reg.scl_d & ~s_reg.sda_d & s_reg.sda_s2;

  // -------------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    rd_load = 1'b0;
    clr_vec = 8'h00;
    s_next.pin_s1 = pin_in;
    s_next.level = s_reg.pin_s1;
    s_next.scl_s1 = scl;
    s_next.scl_s2 = s_reg.scl_s1;
    s_next.scl_d = s_reg.scl_s2;
    s_next.sda_s1 = sda_i;
    s_next.sda_s2 = s_reg.sda_s1;
    s_next.sda_d = s_reg.sda_s2;
    s_next.tog_s1 = bit_tog;
    s_next.tog_s2 = s_reg.tog_s1;
    s_next.tog_d = s_reg.tog_s2;
    if (start_c) begin
      s_next.st = GPI_ADDR;
      s_next.cnt = 3'h0;
      s_next.sda_oe = 1'b0;
    end else if (stop_c) begin
      s_next.st = GPI_IDLE;
      s_next.sda_oe = 1'b0;
    end else begin
      unique case (s_reg.st)
        GPI_IDLE: begin
          s_next.sda_oe = 1'b0;
        end
        GPI_ADDR, GPI_PTR, GPI_WDATA: begin
          if (bit_ev) begin
            s_next.sh = {s_reg.sh[6:0], bit_q};
            s_next.cnt = s_reg.cnt + 3'h1;
            s_next.ph = 1'b0;
            if (s_reg.cnt == GPI_LAST_BIT) begin
              if (s_reg.st == GPI_ADDR) begin
                s_next.st = GPI_AACK;
              end else if (s_reg.st == GPI_PTR) begin
                s_next.st = GPI_PACK;
              end else begin
                s_next.st = GPI_WACK;
              end
            end
          end
        end
        GPI_AACK: begin
          if (fall && !s_reg.ph) begin
            if (s_reg.sh[7:1] == DEV_ADDR) begin
              s_next.sda_oe = 1'b1;
              s_next.ph = 1'b1;
              s_next.rnw = s_reg.sh[0];
            end else begin
              s_next.st = GPI_IDLE;
            end
          end else if (fall) begin
            s_next.cnt = 3'h0;
            if (s_reg.rnw) begin
              rd_load = 1'b1;
              s_next.sh = rd_data;
              s_next.sda_oe = ~rd_data[7];
              s_next.st = GPI_RDATA;
            end else begin
              s_next.sda_oe = 1'b0;
              s_next.st = GPI_PTR;
            end
          end
        end
        GPI_PACK: begin
          if (fall && !s_reg.ph) begin
            s_next.sda_oe = 1'b1;
            s_next.ph = 1'b1;
            s_next.ptr = s_reg.sh;
            s_next.wr_done = 1'b0;
          end else if (fall) begin
            s_next.sda_oe = 1'b0;
            s_next.cnt = 3'h0;
            s_next.st = GPI_WDATA;
          end
        end
        GPI_WACK: begin
          if (fall && !s_reg.ph) begin
            s_next.ph = 1'b1;
            // only the first data byte lands; later ones are not acknowledged
            if (!s_reg.wr_done) begin
              s_next.sda_oe = 1'b1;
              s_next.wr_done = 1'b1;
              unique case (s_reg.ptr)
                GPI_OFF_DIR: s_next.dir = s_reg.sh;
                GPI_OFF_EXPECT: s_next.expect_lvl = s_reg.sh;
                GPI_OFF_PULL_EN: s_next.pull_en = s_reg.sh;
                GPI_OFF_PULL_DIR: s_next.pull_dir = s_reg.sh;
                GPI_OFF_MASK: s_next.mask = s_reg.sh;
                default: s_next.sda_oe = 1'b1;
              endcase
            end else begin
              s_next.sda_oe = 1'b0;
            end
          end else if (fall) begin
            s_next.sda_oe = 1'b0;
            s_next.cnt = 3'h0;
            s_next.st = GPI_WDATA;
          end
        end
        GPI_RDATA: begin
          if (fall) begin
            if (s_reg.cnt == GPI_LAST_BIT) begin
              s_next.sda_oe = 1'b0;
              s_next.ph = 1'b0;
              s_next.st = GPI_MACK;
            end else begin
              s_next.cnt = s_reg.cnt + 3'h1;
              s_next.sh = {s_reg.sh[6:0], 1'b0};
              s_next.sda_oe = ~s_reg.sh[6];
            end
          end
        end
        GPI_MACK: begin
          if (bit_ev) begin
            if (bit_q) begin
              s_next.st = GPI_IDLE;
            end else begin
              s_next.ph = 1'b1;
            end
          end else if (fall && s_reg.ph) begin
            // no auto-increment: an acknowledged read repeats the same register
            rd_load = 1'b1;
            s_next.sh = rd_data;
            s_next.sda_oe = ~rd_data[7];
            s_next.cnt = 3'h0;
            s_next.st = GPI_RDATA;
          end
        end
        default: begin
          s_next.st = GPI_IDLE;
          s_next.sda_oe = 1'b0;
        end
      endcase
    end
    // read clears flags, but a new set in the same cycle wins
    if (rd_load && s_reg.ptr == GPI_OFF_FLAGS) begin
      clr_vec = 8'hff;
    end
    s_next.flags = (s_reg.flags & ~clr_vec) | set_vec;
    s_next.armed = (s_reg.armed & ~set_vec) | rearm_vec;
    s_next.int_oe = |(s_reg.flags & ~s_reg.mask & ~s_reg.dir);
    s_next.pull_up = s_reg.pull_en & s_reg.pull_dir & ~s_reg.dir;
    s_next.pull_dn = s_reg.pull_en & ~s_reg.pull_dir & ~s_reg.dir;
  end

  // -------------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.st <= GPI_IDLE;
      s_reg.dir <= GPI_RST_DIR;
      s_reg.expect_lvl <= GPI_RST_EXPECT;
      s_reg.pull_en <= GPI_RST_PULL_EN;
      s_reg.pull_dir <= GPI_RST_PULL_DIR;
      s_reg.mask <= GPI_RST_MASK;
      s_reg.flags <= GPI_RST_FLAGS;
      s_reg.armed <= GPI_RST_ARMED;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // open-drain lines only ever pull low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_o <= 1'b0;
      int_n_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      int_n_o <= 1'b0;
    end
  end

  assign sda_oe = s_reg.sda_oe;
  assign int_oe = s_reg.int_oe;
  assign pull_up_en = s_reg.pull_up;
  assign pull_dn_en = s_reg.pull_dn;

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  chk_int_follow: assert property (@(posedge clk) disable iff (rst)
    ce |=> int_oe == $past(|(s_reg.flags & ~s_reg.mask & ~s_reg.dir)))
    else $error("interrupt does not follow unmasked input flags");
  chk_flag_set: assert property (@(posedge clk) disable iff (rst)
    ce |=> (s_reg.flags & $past(set_vec)) == $past(set_vec))
    else $error("departure from default did not set flag");
  chk_no_rearm: assert property (@(posedge clk) disable iff (rst)
    ce |=> (s_reg.flags & ~$past(s_reg.flags) & ~$past(s_reg.armed)) == 8'h00)
    else $error("flag rose without return to default");
  chk_out_noflag: assert property (@(posedge clk) disable iff (rst)
    ce |=> (s_reg.flags & ~$past(s_reg.flags) & $past(s_reg.dir)) == 8'h00)
    else $error("output pin raised a flag");
  chk_pull_up: assert property (@(posedge clk) disable iff (rst)
    ce |=> pull_up_en == $past(s_reg.pull_en & s_reg.pull_dir & ~s_reg.dir))
    else $error("pull-up enable wrong");
  chk_pull_dn: assert property (@(posedge clk) disable iff (rst)
    ce |=> pull_dn_en == $past(s_reg.pull_en & ~s_reg.pull_dir & ~s_reg.dir))
    else $error("pull-down enable wrong");
  chk_read_clear: assert property (@(posedge clk) disable iff (rst)
    ce && rd_load && s_reg.ptr == GPI_OFF_FLAGS |=> (s_reg.flags & ~$past(set_vec)) == 8'h00)
    else $error("flag read did not clear flags");
  chk_level_read: assert property (@(posedge clk) disable iff (rst)
    ce && rd_load && s_reg.ptr == GPI_OFF_LEVEL |=> s_reg.sh == $past(s_reg.level))
    else $error("level read returned wrong byte");
  chk_burst_nack: assert property (@(posedge clk) disable iff (rst)
    ce && s_reg.st == GPI_WACK && fall && !s_reg.ph && s_reg.wr_done && !start_c && !stop_c |=> !sda_oe)
    else $error("second write byte was acknowledged");
  cov_flag: cover property (@(posedge clk) disable iff (rst) ce && |set_vec);
  cov_clear: cover property (@(posedge clk) disable iff (rst) ce && rd_load && s_reg.ptr == GPI_OFF_FLAGS);
  cov_write: cover property (@(posedge clk) disable iff (rst) ce && s_reg.st == GPI_WACK && fall && !s_reg.ph);
  cov_int: cover property (@(posedge clk) disable iff (rst) $rose(int_oe));
endmodule
`default_nettype wire

// *** gpi_host.sv ***
// serial bus master model: single-register writes and reads
`timescale 1ns/1ps
`default_nettype none
module gpi_host
  import gpi_pkg::*;
#(
  parameter logic [6:0] ADDR = GPI_DEV_ADDR_DFLT
) (
  output logic scl,
  output logic sda_oe,
  input wire logic sda,
  output logic [7:0] rd_q,
  output logic rd_v
);
  // 17 ns quarter keeps serial edges drifting against clk, phases stay above 32 ns
  localparam time TQ = 17;
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
    rd_q = 8'h00;
    rd_v = 1'b0;
  end
  // data changes only while scl is low; sampled late in the high phase
  task automatic bit_x(input logic b, output logic r);
    #TQ sda_oe = ~b;
    #TQ scl = 1'b1;
    #(2*TQ) r = sda;
    scl = 1'b0;
  endtask
  // start and repeated start share one shape
  task automatic start_x();
    #TQ sda_oe = 1'b0;
    #TQ scl = 1'b1;
    #TQ sda_oe = 1'b1;
    #TQ scl = 1'b0;
  endtask
  // scl stands high after stop until the next frame
  task automatic stop_x();
    #TQ sda_oe = 1'b1;
    #TQ scl = 1'b1;
    #TQ sda_oe = 1'b0;
    #TQ;
  endtask
  task automatic byte_x(input logic [7:0] d, input logic last, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(last, a);
  endtask
  // one register per frame, no burst
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] q;
    start_x();
    byte_x({ADDR, 1'b0}, 1'b1, q);
    byte_x(p, 1'b1, q);
    byte_x(d, 1'b1, q);
    stop_x();
  endtask
  // a second data byte in one write must find no acknowledge
  task automatic wr2(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1, output logic nak);
    logic [7:0] q;
    start_x();
    byte_x({ADDR, 1'b0}, 1'b1, q);
    byte_x(p, 1'b1, q);
    byte_x(d0, 1'b1, q);
    for (int i = 7; i >= 0; i--) bit_x(d1[i], q[i]);
    bit_x(1'b1, nak);
    stop_x();
  endtask
  // master nacks the single data byte
  task automatic rd(input logic [7:0] p);
    logic [7:0] q;
    start_x();
    byte_x({ADDR, 1'b0}, 1'b1, q);
    byte_x(p, 1'b1, q);
    start_x();
    byte_x({ADDR, 1'b1}, 1'b1, q);
    byte_x(8'hff, 1'b1, q);
    stop_x();
    rd_q = q;
    rd_v = 1'b1;
    #1 rd_v = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** gpio_input_pull_and_irq_tb.sv ***
// self-checking bench of the gpio input block driven by a serial master model
`timescale 1ns/1ps
`default_nettype none
module gpio_input_pull_and_irq_tb
  import gpi_pkg::*;
;
  logic clk, rst, ce, scl, m_oe, sda_o, sda_oe, int_n_o, int_oe, rd_v;
  logic [7:0] pin_in, pull_up_en, pull_dn_en, rd_q;
  logic [7:0] exp_q [$];
  logic [7:0] offs [4] = '{GPI_OFF_EXPECT, GPI_OFF_PULL_EN, GPI_OFF_PULL_DIR, GPI_OFF_MASK};
  logic [7:0] rstv [4] = '{GPI_RST_EXPECT, GPI_RST_PULL_EN, GPI_RST_PULL_DIR, GPI_RST_MASK};
  logic [7:0] v [4];
  logic [31:0] seed;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  wire logic sda;
  wire logic int_line;
  logic nak;
  // data line has a pull-up; any pull-down wins
  assign sda = ~(m_oe | (sda_oe & ~sda_o));
  // interrupt line has a pull-up as well
  assign int_line = ~(int_oe & ~int_n_o);
  gpi_top i_dut (.clk(clk), .rst(rst), .ce(ce), .scl(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .pin_in(pin_in), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en),
    .int_n_o(int_n_o), .int_oe(int_oe));
  gpi_host i_host (.scl(scl), .sda_oe(m_oe), .sda(sda), .rd_q(rd_q), .rd_v(rd_v));
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk(input logic [7:0] p, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.rd(p);
  endtask
  // pins move after clk; wait out sync, flag and interrupt latency
  task automatic setp(input logic [7:0] x);
    @(posedge clk);
    #1 pin_in = x;
    repeat (8) @(posedge clk);
  endtask
  task automatic test_done();
    $display("comparisons %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // clock, watcher, timeout
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // reads made only to clear flags carry no note
  always @(posedge rd_v) begin
    if (exp_q.size() > 0) cmp("read byte", exp_q.pop_front(), rd_q);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      test_done();
    end
  end
  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    pin_in = 8'h00;
    seed = 32'h51d72d82;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    repeat (8) @(posedge clk);
    cmp("pull_dn_en", 8'hff, pull_dn_en);
    cmp("pull_up_en", 8'h00, pull_up_en);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      v[i] = seed[7:0];
      chk(offs[i], rstv[i]);
      i_host.wr(offs[i], v[i]);
      chk(offs[i], v[i]);
    end
    cmp("pull_up_en", v[1] & v[2], pull_up_en);
    cmp("pull_dn_en", v[1] & ~v[2], pull_dn_en);
    i_host.wr(GPI_OFF_DIR, 8'hf0);
    cmp("pull_up_en", v[1] & v[2] & 8'h0f, pull_up_en);
    cmp("pull_dn_en", v[1] & ~v[2] & 8'h0f, pull_dn_en);
    chk(8'h02, GPI_RD_UNMAPPED);
    i_host.wr(GPI_OFF_DIR, 8'h00);
    i_host.wr(GPI_OFF_MASK, 8'h00);
    i_host.wr(GPI_OFF_EXPECT, 8'h00);
    seed = lfsr(seed);
    setp(seed[7:0]);
    i_host.wr(GPI_OFF_LEVEL, ~seed[7:0]);
    chk(GPI_OFF_LEVEL, seed[7:0]);
    setp(8'h00);
    i_host.rd(GPI_OFF_FLAGS);
    setp(8'h81);
    cmp("int_oe", 8'h01, {7'h00, int_oe});
    cmp("int line", 8'h00, {7'h00, int_line});
    chk(GPI_OFF_FLAGS, 8'h81);
    cmp("int_oe", 8'h00, {7'h00, int_oe});
    chk(GPI_OFF_FLAGS, 8'h00);
    setp(8'h00);
    setp(8'h81);
    chk(GPI_OFF_FLAGS, 8'h81);
    setp(8'h00);
    i_host.wr(GPI_OFF_MASK, 8'h80);
    setp(8'h80);
    cmp("int_oe", 8'h00, {7'h00, int_oe});
    i_host.wr(GPI_OFF_MASK, 8'h00);
    cmp("int_oe", 8'h01, {7'h00, int_oe});
    chk(GPI_OFF_FLAGS, 8'h80);
    i_host.wr(GPI_OFF_EXPECT, 8'hff);
    chk(GPI_OFF_FLAGS, 8'h7f);
    setp(8'hff);
    setp(8'hfe);
    chk(GPI_OFF_FLAGS, 8'h01);
    i_host.wr(GPI_OFF_DIR, 8'h01);
    setp(8'hff);
    setp(8'hfe);
    cmp("int_oe", 8'h00, {7'h00, int_oe});
    chk(GPI_OFF_FLAGS, 8'h00);
    // second data byte of one write is refused and not stored
    i_host.wr2(GPI_OFF_MASK, 8'h0f, 8'hf0, nak);
    cmp("burst nak", 8'h01, {7'h00, nak});
    chk(GPI_OFF_MASK, 8'h0f);
    // a low clock enable holds the flags and the interrupt
    @(posedge clk);
    #1 ce = 1'b0;
    setp(8'h7e);
    cmp("int_oe", 8'h00, {7'h00, int_oe});
    #1 ce = 1'b1;
    repeat (8) @(posedge clk);
    cmp("int_oe", 8'h01, {7'h00, int_oe});
    chk(GPI_OFF_FLAGS, 8'h80);
    repeat (4) @(posedge clk);
    test_done();
  end
endmodule
`default_nettype wire
